// *** hdl/dsp_fifo.sv ***
`timescale 1ns/1ps
module dsp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_srst,
  dsp_stream_if.snk wr,
  dsp_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] wptr_d;
  logic [AW-1:0] rptr_q;
  logic [AW-1:0] rptr_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic room_q;
  logic room_d;
  logic empty_q;
  logic empty_d;
  logic push;
  logic pop;

  // Flags are registered so the top can present ready straight from a flop
  // Ready stays low in reset and rises the first edge after release
  assign wr.ready = room_q;
  assign rd.valid = ~empty_q;
  assign rd.data = mem[rptr_q];

  always_comb begin
    push = wr.valid & room_q;
    pop = rd.ready & ~empty_q;
    wptr_d = push ? AW'(wptr_q + 1'b1) : wptr_q;
    rptr_d = pop ? AW'(rptr_q + 1'b1) : rptr_q;
    cnt_d = CW'(cnt_q + CW'(push) - CW'(pop));
    room_d = (cnt_d != CW'(DEPTH));
    empty_d = (cnt_d == '0);
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wptr_q] <= wr.data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
      room_q <= 1'b0;
      empty_q <= 1'b1;
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      cnt_q <= cnt_d;
      room_q <= room_d;
      empty_q <= empty_d;
    end
  end
endmodule : dsp_fifo

// *** hdl/dsp_pkg.sv ***
package dsp_pkg;
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int BIT_CNT_W = 4;
  localparam logic [3:0] CNT_LOAD = 4'hF;
  localparam logic [3:0] LAST_BIT = 4'hF;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [3:0] SYNC_RST = 4'h0;
  localparam int SCK_PERIOD_NS = 200;
  localparam int CLK_PERIOD_NS = 25;
  // Each shift-clock phase must span at least this many system clocks
  localparam int SCK_HALF_CYCLES = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  typedef enum logic [3:0] {
    OS_IDLE = 4'h1,
    OS_ARMED = 4'h2,
    OS_SHIFT = 4'h4,
    OS_TAIL = 4'h8
  } dsp_out_state_t;
endpackage : dsp_pkg

// *** hdl/dsp_serial_port.sv ***
`timescale 1ns/1ps
module dsp_serial_port (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_shift_clk,
  input wire logic i_serial_data,
  input wire logic i_serial_in_enable_n,
  input wire logic i_serial_out_enable_n,
  output logic o_serial_data,
  output logic o_serial_data_oe_n,
  output logic o_serial_out_request,
  input wire logic [dsp_pkg::WORD_W-1:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  output logic [dsp_pkg::WORD_W-1:0] o_rx_data,
  output logic o_rx_valid
);
  localparam int W = dsp_pkg::WORD_W;

  dsp_stream_if #(.WIDTH(W)) tx_in ();
  dsp_stream_if #(.WIDTH(W)) tx_out ();

  dsp_fifo #(.WIDTH(W), .DEPTH(dsp_pkg::FIFO_DEPTH)) u_tx_fifo (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .wr(tx_in.snk),
    .rd(tx_out.src)
  );

  assign tx_in.valid = i_tx_valid;
  assign tx_in.data = i_tx_data;
  assign o_tx_ready = tx_in.ready;

  // Pins in order: shift clock, data in, input enable, output enable
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic sck3_q;
  logic sck_rise;
  logic sck_fall;
  logic si_s;
  logic ien_s;
  logic oen_s;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sync1_q <= dsp_pkg::SYNC_RST;
      sync2_q <= dsp_pkg::SYNC_RST;
      sck3_q <= 1'b0;
    end else begin
      sync1_q <= {i_shift_clk, i_serial_data, ~i_serial_in_enable_n, ~i_serial_out_enable_n};
      sync2_q <= sync1_q;
      sck3_q <= sync2_q[3];
    end
  end

  // All four pins share the same latency, so setup taken at the pins holds here
  always_comb begin
    sck_rise = sync2_q[3] & ~sck3_q;
    sck_fall = ~sync2_q[3] & sck3_q;
    si_s = sync2_q[2];
    ien_s = sync2_q[1];
    oen_s = sync2_q[0];
  end

  // Output side
  dsp_pkg::dsp_out_state_t st_q;
  dsp_pkg::dsp_out_state_t st_d;
  logic [W-1:0] shreg_q;
  logic [W-1:0] shreg_d;
  logic [dsp_pkg::BIT_CNT_W-1:0] cnt_q;
  logic [dsp_pkg::BIT_CNT_W-1:0] cnt_d;
  logic req_q;
  logic req_d;
  logic sd_q;
  logic sd_d;
  logic oe_n_q;
  logic oe_n_d;
  logic pop;
  logic msb;

  assign msb = shreg_q[W-1];
  assign tx_out.ready = pop;

  always_comb begin
    st_d = st_q;
    shreg_d = shreg_q;
    cnt_d = cnt_q;
    req_d = req_q;
    sd_d = sd_q;
    oe_n_d = oe_n_q;
    pop = 1'b0;
    case (st_q)
      dsp_pkg::OS_IDLE: begin
        // Word loads on a rise so the request follows that rise
        if (sck_rise && tx_out.valid) begin
          pop = 1'b1;
          shreg_d = tx_out.data;
          cnt_d = dsp_pkg::CNT_LOAD;
          req_d = 1'b1;
          st_d = dsp_pkg::OS_ARMED;
        end
      end
      dsp_pkg::OS_ARMED: begin
        // Enable seen at any fall, same period as request included
        if (sck_fall && oen_s) begin
          sd_d = shreg_q[W-1];
          oe_n_d = 1'b0;
          shreg_d = {shreg_q[W-2:0], 1'b0};
          cnt_d = dsp_pkg::BIT_CNT_W'(cnt_q + 1'b1);
          st_d = dsp_pkg::OS_SHIFT;
        end
      end
      dsp_pkg::OS_SHIFT: begin
        if (sck_rise && cnt_q == dsp_pkg::LAST_BIT) begin
          req_d = 1'b0;
          st_d = dsp_pkg::OS_TAIL;
        end else if (sck_fall) begin
          if (oen_s) begin
            sd_d = shreg_q[W-1];
            shreg_d = {shreg_q[W-2:0], 1'b0};
            cnt_d = dsp_pkg::BIT_CNT_W'(cnt_q + 1'b1);
          end else begin
            // Released: pause, word position kept for a later resume
            oe_n_d = 1'b1;
            st_d = dsp_pkg::OS_ARMED;
          end
        end
      end
      dsp_pkg::OS_TAIL: begin
        // Last bit stays on the wire until the next fall
        if (sck_fall) begin
          oe_n_d = 1'b1;
          sd_d = 1'b0;
          st_d = dsp_pkg::OS_IDLE;
        end
      end
      default: begin
        st_d = dsp_pkg::OS_IDLE;
        req_d = 1'b0;
        oe_n_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_q <= dsp_pkg::OS_IDLE;
      shreg_q <= dsp_pkg::WORD_RST;
      cnt_q <= dsp_pkg::CNT_RST;
      req_q <= 1'b0;
      sd_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      st_q <= st_d;
      shreg_q <= shreg_d;
      cnt_q <= cnt_d;
      req_q <= req_d;
      sd_q <= sd_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign o_serial_data = sd_q;
  assign o_serial_data_oe_n = oe_n_q;
  assign o_serial_out_request = req_q;

  // Input side
  logic [W-1:0] rx_sh_q;
  logic [W-1:0] rx_sh_d;
  logic [dsp_pkg::BIT_CNT_W-1:0] rx_cnt_q;
  logic [dsp_pkg::BIT_CNT_W-1:0] rx_cnt_d;
  logic [W-1:0] rx_data_q;
  logic [W-1:0] rx_data_d;
  logic rx_valid_q;
  logic rx_valid_d;

  always_comb begin
    rx_sh_d = rx_sh_q;
    rx_cnt_d = rx_cnt_q;
    rx_data_d = rx_data_q;
    rx_valid_d = 1'b0;
    if (sck_rise && ien_s) begin
      rx_sh_d = {rx_sh_q[W-2:0], si_s};
      rx_cnt_d = dsp_pkg::BIT_CNT_W'(rx_cnt_q + 1'b1);
      if (rx_cnt_q == dsp_pkg::LAST_BIT) begin
        rx_data_d = {rx_sh_q[W-2:0], si_s};
        rx_valid_d = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rx_sh_q <= dsp_pkg::WORD_RST;
      rx_cnt_q <= dsp_pkg::CNT_RST;
      rx_data_q <= dsp_pkg::WORD_RST;
      rx_valid_q <= 1'b0;
    end else begin
      rx_sh_q <= rx_sh_d;
      rx_cnt_q <= rx_cnt_d;
      rx_data_q <= rx_data_d;
      rx_valid_q <= rx_valid_d;
    end
  end

  assign o_rx_data = rx_data_q;
  assign o_rx_valid = rx_valid_q;

  property p_req_on_load;
    @(posedge i_clk) disable iff (i_srst)
    (st_q == dsp_pkg::OS_IDLE && sck_rise && tx_out.valid) |=> req_q && st_q == dsp_pkg::OS_ARMED;
  endproperty
  a_req_on_load: assert property (p_req_on_load) else $error("request not raised on load");

  property p_first_bit;
    @(posedge i_clk) disable iff (i_srst)
    (st_q == dsp_pkg::OS_ARMED && sck_fall && oen_s) |=> !o_serial_data_oe_n && o_serial_data == $past(msb);
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first bit not driven");

  property p_wait_enable;
    @(posedge i_clk) disable iff (i_srst)
    (st_q == dsp_pkg::OS_ARMED && !oen_s) |=> o_serial_data_oe_n;
  endproperty
  a_wait_enable: assert property (p_wait_enable) else $error("driven without enable");

  property p_next_bit;
    @(posedge i_clk) disable iff (i_srst)
    (st_q == dsp_pkg::OS_SHIFT && sck_fall && oen_s && !sck_rise) |=>
      o_serial_data == $past(msb) ##1 $stable(o_serial_data);
  endproperty
  a_next_bit: assert property (p_next_bit) else $error("bit not presented after fall");

  property p_release_float;
    @(posedge i_clk) disable iff (i_srst)
    (st_q == dsp_pkg::OS_SHIFT && sck_fall && !oen_s) |=> o_serial_data_oe_n && req_q;
  endproperty
  a_release_float: assert property (p_release_float) else $error("output not floated");

  property p_req_drop;
    @(posedge i_clk) disable iff (i_srst)
    (st_q == dsp_pkg::OS_SHIFT && sck_rise && cnt_q == dsp_pkg::LAST_BIT) |=>
      !req_q && !o_serial_data_oe_n;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("request not dropped");

  property p_tail_float;
    @(posedge i_clk) disable iff (i_srst)
    (st_q == dsp_pkg::OS_TAIL && sck_fall) |=>
      o_serial_data_oe_n && !req_q && st_q == dsp_pkg::OS_IDLE;
  endproperty
  a_tail_float: assert property (p_tail_float) else $error("last bit not floated");

  property p_rx_capture;
    @(posedge i_clk) disable iff (i_srst)
    (sck_rise && ien_s) |=> rx_cnt_q == dsp_pkg::BIT_CNT_W'($past(rx_cnt_q) + 1'b1);
  endproperty
  a_rx_capture: assert property (p_rx_capture) else $error("input bit not captured");

  property p_rx_ignore;
    @(posedge i_clk) disable iff (i_srst)
    (!(sck_rise && ien_s)) |=> $stable(rx_cnt_q) && $stable(rx_sh_q);
  endproperty
  a_rx_ignore: assert property (p_rx_ignore) else $error("input captured while disabled");

  property p_sync_depth;
    @(posedge i_clk) disable iff (i_srst)
    (i_shift_clk ##1 i_shift_clk) |=> sync2_q[3];
  endproperty
  a_sync_depth: assert property (p_sync_depth) else $error("synchroniser depth wrong");
endmodule : dsp_serial_port

// *** hdl/dsp_stream_if.sv ***
`timescale 1ns/1ps
interface dsp_stream_if #(
  parameter int WIDTH = 16
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : dsp_stream_if

// *** verif/dsp_partner.sv ***
`timescale 1ns/1ps
module dsp_partner (
  output logic o_sck,
  output logic o_sdi,
  output logic o_in_en_n,
  output logic o_out_en_n,
  input wire logic i_sdo,
  input wire logic i_sdo_oe_n
);
  logic [15:0] din;
  logic [15:0] got;
  int nbits;
  initial begin
    o_sck = 1'b0;
    o_in_en_n = 1'b1;
    o_out_en_n = 1'b1;
    din = 16'h0000;
    got = 16'h0000;
    nbits = 0;
  end
  // Unselected data line shows the inverse, so a stale bit never passes
  assign o_sdi = o_in_en_n ? ~din[15] : din[15];
  // Enables move mid low phase, clear of both edges
  task automatic cycle(input logic en_out_n, input logic en_in_n);
    #50;
    o_out_en_n = en_out_n;
    o_in_en_n = en_in_n;
    #50;
    o_sck = 1'b1;
    if (i_sdo_oe_n === 1'b0) begin
      got = {got[14:0], i_sdo};
      nbits++;
    end
    #100;
    o_sck = 1'b0;
    if (o_in_en_n === 1'b0) begin
      din = {din[14:0], 1'b0};
    end
  endtask : cycle
  // Output enable moves in the high phase, still a full setup ahead of the fall
  task automatic cycle_mid(input logic en_out_n);
    #100;
    o_sck = 1'b1;
    if (i_sdo_oe_n === 1'b0) begin
      got = {got[14:0], i_sdo};
      nbits++;
    end
    #50;
    o_out_en_n = en_out_n;
    #50;
    o_sck = 1'b0;
  endtask : cycle_mid
endmodule : dsp_partner

// *** verif/dsp_serial_port_tb.sv ***
`timescale 1ns/1ps
module dsp_serial_port_tb;
  logic i_clk;
  logic i_srst;
  logic sck, sdi, ien_n, oen_n, sdo, sdo_oe_n, req, tx_valid, tx_ready, rx_valid;
  logic [15:0] tx_data;
  logic [15:0] rx_data;
  logic [15:0] rx_last;
  int n_mismatch;
  int samples_checked;
  int rx_cnt;

  dsp_serial_port DUT (.i_clk(i_clk), .i_srst(i_srst), .i_shift_clk(sck),
    .i_serial_data(sdi), .i_serial_in_enable_n(ien_n), .i_serial_out_enable_n(oen_n),
    .o_serial_data(sdo), .o_serial_data_oe_n(sdo_oe_n), .o_serial_out_request(req),
    .i_tx_data(tx_data), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
    .o_rx_data(rx_data), .o_rx_valid(rx_valid));
  dsp_partner u_part (.o_sck(sck), .o_sdi(sdi), .o_in_en_n(ien_n), .o_out_en_n(oen_n),
    .i_sdo(sdo), .i_sdo_oe_n(sdo_oe_n));

  always #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (rx_valid === 1'b1) begin
      rx_cnt++;
      rx_last = rx_data;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  function automatic logic [15:0] wd(input int k);
    return 16'hA5C3 ^ 16'(k * 16'h0F11);
  endfunction : wd

  // One outgoing word; pre cycles idle first, pause of two cycles at pa
  task automatic frame(input logic [15:0] exp, input int pre, input int pa);
    int n;
    n = 17 + pre + ((pa > 0) ? 2 : 0);
    u_part.got = 16'h0000;
    u_part.nbits = 0;
    for (int i = 0; i < n; i++) begin
      u_part.cycle((i < pre) || (pa > 0 && i >= pa && i < pa + 2), 1'b1);
      if (i == 0) check(req, 1'b1);
      if (pa > 0 && i == pa + 1) check(sdo_oe_n, 1'b1);
    end
    #100;
    check(u_part.got, exp);
    check(16'(u_part.nbits), 16'h0010);
    check(req, 1'b0);
    check(sdo_oe_n, 1'b1);
  endtask : frame

  task automatic t_fill();
    int k;
    check(req, 1'b0);
    check(sdo_oe_n, 1'b1);
    k = 0;
    while (tx_ready === 1'b1 && k < 20) begin
      tx_valid = 1'b1;
      tx_data = wd(k);
      k++;
      @(negedge i_clk);
    end
    // Refused word kept up one cycle; it must never come out
    tx_data = 16'hFFFF;
    @(negedge i_clk);
    tx_valid = 1'b0;
    check(16'(k), 16'(dsp_pkg::FIFO_DEPTH));
    $display("fill done");
  endtask : t_fill

  task automatic t_drain();
    for (int k = 0; k < 16; k++) begin
      frame(wd(k), 0, (k == 5) ? 8 : 0);
    end
    $display("drain done");
  endtask : t_drain

  task automatic t_late();
    @(negedge i_clk);
    tx_valid = 1'b1;
    tx_data = wd(16);
    @(negedge i_clk);
    tx_valid = 1'b0;
    frame(wd(16), 1, 0);
    $display("late enable done");
  endtask : t_late

  task automatic t_rx();
    u_part.din = 16'h3C96;
    for (int i = 0; i < 20; i++) begin
      u_part.cycle(1'b1, (i >= 5 && i < 9));
    end
    #200;
    check(16'(rx_cnt), 16'h0001);
    check(rx_last, 16'h3C96);
    $display("receive done");
  endtask : t_rx

  // Enable comes in the very period whose rise raised the request
  task automatic t_same();
    @(negedge i_clk);
    tx_valid = 1'b1;
    tx_data = wd(17);
    @(negedge i_clk);
    tx_valid = 1'b0;
    u_part.got = 16'h0000;
    u_part.nbits = 0;
    u_part.cycle_mid(1'b0);
    check(req, 1'b1);
    for (int i = 0; i < 16; i++) begin
      u_part.cycle(1'b0, 1'b1);
    end
    #100;
    check(u_part.got, wd(17));
    check(16'(u_part.nbits), 16'h0010);
    check(req, 1'b0);
    check(sdo_oe_n, 1'b1);
    $display("same period enable done");
  endtask : t_same

  initial begin
    i_clk = 1'b0;
    i_srst = 1'b1;
    tx_valid = 1'b0;
    tx_data = 16'h0000;
    n_mismatch = 0;
    samples_checked = 0;
    rx_cnt = 0;
    repeat (3) @(negedge i_clk);
    i_srst = 1'b0;
    repeat (4) @(negedge i_clk);
    t_fill();
    t_drain();
    t_late();
    t_rx();
    t_same();
    results();
  end

  // All tests need about 70 us; allow four times that
  initial begin
    #300000;
    n_mismatch++;
    results();
  end
endmodule : dsp_serial_port_tb
